// ### hdl/wdsl_pkg.sv
//----------------------------------------------------------------
// shared constants for the watchdog block
//----------------------------------------------------------------
package wdsl_pkg;

	// clock rates; the watchdog oscillator is derived from the bus clock
	localparam int unsigned CLK_HZ           = 20_000_000;
	localparam int unsigned OSC_HZ           = 1_000_000;
	localparam int unsigned OSC_DIV          = CLK_HZ / OSC_HZ;
	localparam int unsigned OSC_DIV_W        = 5;
	localparam logic [4:0]  OSC_DIV_LAST     = OSC_DIV_W'(OSC_DIV - 1);

	// change window length in bus clock cycles
	localparam int unsigned CE_WINDOW_CYCLES = 4;
	localparam logic [2:0]  CE_CNT_LAST      = 3'(CE_WINDOW_CYCLES - 1);

	// shortest time-out in oscillator cycles, code 000
	localparam int unsigned BASE_TICKS       = 16384;
	localparam int unsigned CNT_W            = 22;

	// register byte addresses, decoded on the low address bits
	localparam int unsigned ADDR_W           = 12;
	localparam logic [11:0] CTRL_ADDR        = 12'h000;
	localparam logic [11:0] STAT_ADDR        = 12'h004;

	// watchdog_control field positions
	localparam int unsigned CE_BIT           = 4;
	localparam int unsigned EN_BIT           = 3;
	localparam int unsigned PS_W             = 3;

	// reset_status_register field position
	localparam int unsigned FLAG_BIT         = 3;

	// reset values
	localparam logic [2:0]  PS_RST           = 3'h0;
	localparam logic        EN_RST           = 1'h0;
	localparam logic        CE_RST           = 1'h0;

	// bus encodings
	localparam logic [2:0]  HSIZE_WORD       = 3'h2;
	localparam int unsigned HTRANS_ACT_BIT   = 1;
	localparam logic        HRESP_OKAY       = 1'h0;

	// safety levels chosen by the fuses
	typedef enum logic [1:0] {
		LVL0 = 2'b00,
		LVL1 = 2'b01,
		LVL2 = 2'b10
	} wdsl_lvl_t;

	// bus slave phases
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WR   = 2'b01,
		BUS_RD1  = 2'b10,
		BUS_RD2  = 2'b11
	} wdsl_bus_t;

endpackage

// ### hdl/wdsl_watchdog.sv
// Summary of operation
// - count from derived one megahertz oscillator tick
// - restart instruction clears watchdog counter
// - counter cleared when disabled or reset
// - expiry while enabled resets the device
// - two fuses select safety level zero-two
// - enable by writing one, always allowed
// - upper three control bits read zero
// - change enable self clears after four cycles
// - disable write needs open change window
// - level two stays enabled, reads one
// - prescale code doubles period from 16384
// - level zero accepts any prescale write
// - levels one, two need window for prescale
// - level two ignores written enable value
// - time-out gives one-cycle reset pulse
// - watchdog reset flag, cleared by power-on
`timescale 1ns/10ps
`default_nettype none

module wdsl_watchdog #(
	parameter int unsigned BASE_TICKS = wdsl_pkg::BASE_TICKS
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        power_on_reset,
	input  wire logic        legacy_compat_fuse,
	input  wire logic        always_on_fuse,
	input  wire logic        restart_instruction,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output var  logic [31:0] hrdata,
	output var  logic        hreadyout,
	output var  logic        hresp,
	output var  logic        wd_reset_pulse
);

	//----------------------------------------------------------------
	// fuse synchroniser and safety level
	//----------------------------------------------------------------
	logic [1:0]            fuse_meta_q;   // first stage, read by second only
	logic [1:0]            fuse_sync_q;   // {always_on, compat}
	wdsl_pkg::wdsl_lvl_t   lvl_q;         // current safety level
	wdsl_pkg::wdsl_lvl_t   lvl_d;

	// level from synchronised fuses
	always_comb begin
		if (fuse_sync_q[1]) begin
			lvl_d = wdsl_pkg::LVL2;
		end else if (fuse_sync_q[0]) begin
			lvl_d = wdsl_pkg::LVL0;
		end else begin
			lvl_d = wdsl_pkg::LVL1;
		end
	end

	// fuse registers
	always_ff @(posedge clk) begin
		if (reset) begin
			fuse_meta_q <= 2'h0;
			fuse_sync_q <= 2'h0;
			lvl_q       <= wdsl_pkg::LVL1;
		end else begin
			fuse_meta_q <= {always_on_fuse, legacy_compat_fuse};
			fuse_sync_q <= fuse_meta_q;
			lvl_q       <= lvl_d;
		end
	end

	//----------------------------------------------------------------
	// ahb-lite slave
	//----------------------------------------------------------------
	wdsl_pkg::wdsl_bus_t   bus_q;         // transfer phase
	wdsl_pkg::wdsl_bus_t   bus_d;
	logic [11:0]           addr_q;        // latched address
	logic [11:0]           addr_d;
	logic                  word_q;        // word sized, in low page
	logic                  word_d;
	logic [31:0]           hrdata_q;
	logic [31:0]           hrdata_d;
	logic                  hready_q;
	logic                  hready_d;
	logic                  accept;        // address phase taken
	logic                  wr_ctrl;       // write to control this cycle
	logic                  wr_stat;       // write to status this cycle
	logic [31:0]           rd_mux;        // read value of latched address
	logic                  ce_q;
	logic                  en_q;
	logic                  en_eff;
	logic [2:0]            ps_q;
	logic                  flag_q;

	assign accept  = hsel && htrans[wdsl_pkg::HTRANS_ACT_BIT] && hready;
	assign wr_ctrl = (bus_q == wdsl_pkg::BUS_WR) && word_q && (addr_q == wdsl_pkg::CTRL_ADDR);
	assign wr_stat = (bus_q == wdsl_pkg::BUS_WR) && word_q && (addr_q == wdsl_pkg::STAT_ADDR);

	// read multiplexer; unmapped reads return zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (word_q && addr_q == wdsl_pkg::CTRL_ADDR) begin
			rd_mux[wdsl_pkg::CE_BIT]          = ce_q;
			rd_mux[wdsl_pkg::EN_BIT]          = en_eff;
			rd_mux[wdsl_pkg::PS_W-1:0]        = ps_q;
		end else if (word_q && addr_q == wdsl_pkg::STAT_ADDR) begin
			rd_mux[wdsl_pkg::FLAG_BIT]        = flag_q;
		end
	end

	// phase sequencing; reads take one wait state
	always_comb begin
		bus_d    = bus_q;
		addr_d   = addr_q;
		word_d   = word_q;
		hrdata_d = hrdata_q;
		hready_d = hready_q;
		case (bus_q)
			wdsl_pkg::BUS_IDLE, wdsl_pkg::BUS_WR, wdsl_pkg::BUS_RD2: begin
				if (accept) begin
					addr_d   = haddr[11:0];
					word_d   = (hsize == wdsl_pkg::HSIZE_WORD) && (haddr[31:12] == 20'h00000);
					bus_d    = hwrite ? wdsl_pkg::BUS_WR : wdsl_pkg::BUS_RD1;
					hready_d = hwrite;
				end else begin
					bus_d    = wdsl_pkg::BUS_IDLE;
					hready_d = 1'b1;
				end
			end
			wdsl_pkg::BUS_RD1: begin
				// sample registers after any earlier write has landed
				hrdata_d = rd_mux;
				hready_d = 1'b1;
				bus_d    = wdsl_pkg::BUS_RD2;
			end
			default: begin
				bus_d    = wdsl_pkg::BUS_IDLE;
				hready_d = 1'b1;
			end
		endcase
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (reset) begin
			bus_q    <= wdsl_pkg::BUS_IDLE;
			addr_q   <= 12'h000;
			word_q   <= 1'b0;
			hrdata_q <= 32'h0000_0000;
			hready_q <= 1'b1;
		end else begin
			bus_q    <= bus_d;
			addr_q   <= addr_d;
			word_q   <= word_d;
			hrdata_q <= hrdata_d;
			hready_q <= hready_d;
		end
	end

	assign hrdata    = hrdata_q;
	assign hreadyout = hready_q;
	assign hresp     = wdsl_pkg::HRESP_OKAY;

	//----------------------------------------------------------------
	// watchdog control register and change window
	//----------------------------------------------------------------
	logic                  ce_d;
	logic [2:0]            cecnt_q;       // cycles the window has been open
	logic [2:0]            cecnt_d;
	logic                  en_d;
	logic [2:0]            ps_d;
	logic                  open_wr;       // opening write of a sequence

	assign open_wr = wr_ctrl && hwdata[wdsl_pkg::CE_BIT] && hwdata[wdsl_pkg::EN_BIT];
	assign en_eff  = en_q || (lvl_q == wdsl_pkg::LVL2);

	// control next state
	always_comb begin
		en_d    = en_q;
		ps_d    = ps_q;
		ce_d    = ce_q;
		cecnt_d = cecnt_q;
		if (ce_q) begin
			if (cecnt_q == wdsl_pkg::CE_CNT_LAST) begin
				ce_d = 1'b0;
			end else begin
				cecnt_d = cecnt_q + 3'h1;
			end
		end
		if (wr_ctrl) begin
			if (hwdata[wdsl_pkg::EN_BIT]) begin
				en_d = 1'b1;
			end else if (ce_q && lvl_q != wdsl_pkg::LVL2) begin
				en_d = 1'b0;
			end
			if (lvl_q == wdsl_pkg::LVL0 || ce_q) begin
				ps_d = hwdata[wdsl_pkg::PS_W-1:0];
			end
			// window opened by enable plus change enable
			if (open_wr) begin
				ce_d    = 1'b1;
				cecnt_d = 3'h0;
			end
		end
	end

	// control registers
	always_ff @(posedge clk) begin
		if (reset) begin
			en_q    <= wdsl_pkg::EN_RST;
			ps_q    <= wdsl_pkg::PS_RST;
			ce_q    <= wdsl_pkg::CE_RST;
			cecnt_q <= 3'h0;
		end else begin
			en_q    <= en_d;
			ps_q    <= ps_d;
			ce_q    <= ce_d;
			cecnt_q <= cecnt_d;
		end
	end

	//----------------------------------------------------------------
	// oscillator tick and time-out counter
	//----------------------------------------------------------------
	logic [4:0]                     div_q;   // oscillator divider
	logic [4:0]                     div_d;
	logic                           tick;    // one oscillator cycle
	logic [wdsl_pkg::CNT_W-1:0]     cnt_q;   // oscillator cycles counted
	logic [wdsl_pkg::CNT_W-1:0]     cnt_d;
	logic [wdsl_pkg::CNT_W-1:0]     period_last;
	logic                           wdr_q;   // reset pulse
	logic                           wdr_d;

	assign period_last = (wdsl_pkg::CNT_W'(BASE_TICKS) << ps_q) - wdsl_pkg::CNT_W'(1);
	assign tick        = (div_q == wdsl_pkg::OSC_DIV_LAST);

	// counter next state
	always_comb begin
		div_d = tick ? 5'h00 : div_q + 5'h01;
		cnt_d = cnt_q;
		wdr_d = 1'b0;
		if (!en_eff || restart_instruction) begin
			cnt_d = '0;
		end else if (tick) begin
			if (cnt_q >= period_last) begin
				cnt_d = '0;
				wdr_d = 1'b1;
			end else begin
				cnt_d = cnt_q + wdsl_pkg::CNT_W'(1);
			end
		end
	end

	// counter registers; chip reset clears the count
	always_ff @(posedge clk) begin
		if (reset) begin
			div_q <= 5'h00;
			cnt_q <= '0;
			wdr_q <= 1'b0;
		end else begin
			div_q <= div_d;
			cnt_q <= cnt_d;
			wdr_q <= wdr_d;
		end
	end

	assign wd_reset_pulse = wdr_q;

	//----------------------------------------------------------------
	// watchdog reset flag, survives chip reset
	//----------------------------------------------------------------
	logic                  flag_d;

	// set wins over software clear
	always_comb begin
		flag_d = flag_q;
		if (wr_stat && !hwdata[wdsl_pkg::FLAG_BIT]) begin
			flag_d = 1'b0;
		end
		if (wdr_q) begin
			flag_d = 1'b1;
		end
	end

	// power-on reset clears it, chip reset does not
	always_ff @(posedge clk) begin
		if (power_on_reset) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	//----------------------------------------------------------------
	// assertions
	//----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// opening write followed by four quiet cycles
	sequence s_open_alone;
		open_wr ##1 (!open_wr)[*4];
	endsequence

	// expiry condition on a tick
	sequence s_expire;
		tick && en_eff && !restart_instruction && (cnt_q >= period_last);
	endsequence

	a_window_open: assert property (open_wr |=> ce_q[*4])
		else $error("change window shorter than four cycles");
	a_window_close: assert property (s_open_alone |=> !ce_q)
		else $error("change window not closed after four cycles");
	a_closed_no_disable: assert property ((wr_ctrl && !ce_q) |=> en_eff || !$past(en_eff))
		else $error("watchdog disabled outside change window");
	a_lvl2_stays_on: assert property ((lvl_q == wdsl_pkg::LVL2) && wr_ctrl |=> en_eff)
		else $error("level two watchdog disabled");
	a_ps_locked: assert property ((wr_ctrl && !ce_q && lvl_q != wdsl_pkg::LVL0) |=> $stable(ps_q))
		else $error("prescale changed outside window");
	a_ps_level0: assert property ((wr_ctrl && lvl_q == wdsl_pkg::LVL0) |=> ps_q == $past(hwdata[2:0]))
		else $error("level zero prescale write lost");
	a_restart_clear: assert property (restart_instruction |=> cnt_q == '0)
		else $error("restart did not clear counter");
	a_off_clear: assert property (!en_eff ##1 !en_eff |-> cnt_q == '0)
		else $error("counter runs while disabled");
	a_expire_pulse: assert property (s_expire |=> wdr_q ##1 !wdr_q)
		else $error("time-out pulse wrong");
	a_pulse_cause: assert property ($rose(wdr_q) |-> $past(tick) && $past(en_eff))
		else $error("reset pulse without enabled expiry");
	a_flag_set: assert property ((wdr_q && !power_on_reset) |=> flag_q)
		else $error("watchdog reset flag not set");
	a_reserved_zero: assert property ((bus_q == wdsl_pkg::BUS_RD2) |-> hrdata_q[7:5] == 3'h0)
		else $error("reserved control bits not zero");

endmodule

`default_nettype wire

// ### dv/wdsl_watchdog_test.sv
`timescale 1ns/10ps
`default_nettype none

module wdsl_watchdog_test;

	//----------------------------------------------------------------
	// signals and bench state
	//----------------------------------------------------------------
	logic        clk                 = 1'b0;
	logic        reset               = 1'b1;
	logic        power_on_reset      = 1'b1;
	logic        legacy_compat_fuse  = 1'b0;
	logic        always_on_fuse      = 1'b0;
	logic        restart_instruction = 1'b0;
	logic        hsel                = 1'b0;
	logic [31:0] haddr               = 32'h0;
	logic [1:0]  htrans              = 2'h0;
	logic        hwrite              = 1'b0;
	logic [2:0]  hsize               = 3'h2;
	logic [31:0] hwdata              = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        wd_reset_pulse;
	logic [31:0] rdv;                 // last read data
	logic [31:0] rnd;                 // random draw
	int          err_count           = 0;
	int          cmp_count           = 0;
	int          pulse_count         = 0;
	int          pc;                  // pulse count snapshot
	int          n;                   // cycles waited for a pulse
	int          cyc                 = 0;

	localparam logic [31:0] CTRL = 32'h0;
	localparam logic [31:0] STAT = 32'h4;

	//----------------------------------------------------------------
	// design, short base period so time-outs stay quick
	//----------------------------------------------------------------
	wdsl_watchdog #(.BASE_TICKS(4)) i_wdsl_watchdog (
		.clk                 (clk),
		.reset               (reset),
		.power_on_reset      (power_on_reset),
		.legacy_compat_fuse  (legacy_compat_fuse),
		.always_on_fuse      (always_on_fuse),
		.restart_instruction (restart_instruction),
		.hsel                (hsel),
		.haddr               (haddr),
		.htrans              (htrans),
		.hwrite              (hwrite),
		.hsize               (hsize),
		.hready              (hreadyout),
		.hwdata              (hwdata),
		.hrdata              (hrdata),
		.hreadyout           (hreadyout),
		.hresp               (hresp),
		.wd_reset_pulse      (wd_reset_pulse)
	);

	// 50 ns clock
	always #25 clk = ~clk;

	// pulse counter and hang guard
	always @(posedge clk) begin
		cyc++;
		if (wd_reset_pulse === 1'b1) begin
			pulse_count++;
		end
		if (cyc == 40000) begin
			err_count++;
			close_out();
		end
	end

	//----------------------------------------------------------------
	// expectation functions and tasks
	//----------------------------------------------------------------
	// control readback: enable bit and prescale, all else zero
	function automatic logic [31:0] ctrl_val(input logic en, input logic [2:0] ps);
		return {28'h0, en, ps};
	endfunction

	// time-out in bus clocks for base 4 and divider 20
	function automatic int tmo(input logic [2:0] ps);
		return (4 << ps) * 20;
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single ahb transfer, waits on hready in both phases
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rdv = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask

	// chip reset with fuse setting; por clears the flag as well
	task automatic do_reset(input logic lc, input logic ao, input logic por);
		legacy_compat_fuse <= lc;
		always_on_fuse     <= ao;
		reset              <= 1'b1;
		power_on_reset     <= por;
		repeat (20) @(posedge clk);
		reset              <= 1'b0;
		power_on_reset     <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic wait_pulse(input int lim);
		n = 0;
		while (wd_reset_pulse !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask

	task automatic close_out();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	//----------------------------------------------------------------
	// main sequence
	//----------------------------------------------------------------
	initial begin
		rnd = $urandom(32'h13B2);
		do_reset(1'b0, 1'b0, 1'b1);
		// level 1: disabled, flag clear, unmapped reads zero
		rd_chk(CTRL, ctrl_val(1'b0, 3'h0));
		rd_chk(STAT, 32'h0);
		rd_chk(32'h8, 32'h0);
		rd_chk(32'h1000, 32'h0);
		wr(CTRL, 32'h0F);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h0));
		wr(CTRL, 32'h00);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h0));
		// window closed after four cycles
		wr(CTRL, 32'h18);
		repeat (6) @(posedge clk);
		wr(CTRL, 32'h05);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h0));
		wr(CTRL, 32'h18);
		wr(CTRL, 32'h05);
		// change enable still reads one in the last window cycle
		rd_chk(CTRL, ctrl_val(1'b0, 3'h5) | 32'h10);
		// random restarts hold off the time-out
		wr(CTRL, 32'h18);
		wr(CTRL, 32'h08);
		pc = pulse_count;
		repeat (12) begin
			repeat ($urandom_range(50, 1)) @(posedge clk);
			restart_instruction <= 1'b1;
			@(posedge clk);
			restart_instruction <= 1'b0;
		end
		chk(pulse_count, pc);
		wait_pulse(200);
		chk(32'(n >= tmo(3'h0) - 20 && n <= tmo(3'h0) + 20), 32'h1);
		@(posedge clk);
		chk({31'h0, wd_reset_pulse}, 32'h0);
		rd_chk(STAT, 32'h8);
		do_reset(1'b0, 1'b0, 1'b0);
		rd_chk(STAT, 32'h8);
		rd_chk(CTRL, ctrl_val(1'b0, 3'h0));
		wr(STAT, 32'h8);
		rd_chk(STAT, 32'h8);
		wr(STAT, 32'h0);
		rd_chk(STAT, 32'h0);
		// disable in mid-count clears the counter
		pc = pulse_count;
		wr(CTRL, 32'h08);
		repeat (50) @(posedge clk);
		wr(CTRL, 32'h18);
		wr(CTRL, 32'h00);
		wr(CTRL, 32'h08);
		repeat (50) @(posedge clk);
		chk(pulse_count, pc);
		// level 0: prescale free, reserved bits read zero
		do_reset(1'b1, 1'b0, 1'b0);
		repeat (10) begin
			rnd = $urandom;
			wr(CTRL, {24'h0, rnd[7:5], 2'b01, rnd[2:0]});
			rd_chk(CTRL, ctrl_val(1'b1, rnd[2:0]));
		end
		wr(CTRL, 32'h0A);
		restart_instruction <= 1'b1;
		@(posedge clk);
		restart_instruction <= 1'b0;
		wait_pulse(600);
		chk(32'(n >= tmo(3'h2) - 20 && n <= tmo(3'h2) + 20), 32'h1);
		// flag from the level 0 time-out, then power-on clears it
		rd_chk(STAT, 32'h8);
		// level 2: always on, window still gates prescale
		do_reset(1'b0, 1'b1, 1'b1);
		rd_chk(STAT, 32'h0);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h0));
		wr(CTRL, 32'h18);
		wr(CTRL, 32'h02);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h2) | 32'h10);
		wr(CTRL, 32'h03);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h2));
		wr(CTRL, 32'h18);
		wr(CTRL, 32'h00);
		rd_chk(CTRL, ctrl_val(1'b1, 3'h0) | 32'h10);
		close_out();
	end

endmodule

`default_nettype wire
